// ### verilog/sras_map.vh
// register map, field positions and timing constants for the serial access block
`ifndef SRAS_MAP_VH
`define SRAS_MAP_VH

`define SRAS_FRAME_BITS      6'd40
`define SRAS_ADDR_BITS       7
`define SRAS_DATA_BITS       32
`define SRAS_DIR_READ        1'b1
// eeprom / shadow addresses
`define SRAS_EE_FIRST        7'h0B
`define SRAS_EE_LAST         7'h0F
`define SRAS_SH_FIRST        7'h1B
`define SRAS_SH_LAST         7'h1F
// free-space eeprom needs no access code
`define SRAS_FREE_FIRST      7'h00
`define SRAS_FREE_LAST       7'h0A
// access code register and key (key value arbitrary)
`define SRAS_ACCESS_ADDR     7'h2F
`define SRAS_ACCESS_KEY      32'h5A5A_C0DE
// window selection in word 0x0F
`define SRAS_BYPASS_BIT      24
`define SRAS_N_MSB           23
`define SRAS_N_LSB           14
`define SRAS_N_MIN           10'h004
// ecc status field of a non-volatile read
`define SRAS_ECC_MSB         27
`define SRAS_ECC_LSB         26
`define SRAS_ECC_NONE        2'h0
`define SRAS_ECC_FIXED       2'h1
`define SRAS_ECC_FAIL        2'h2
`define SRAS_EE_DATA_MSB     25
// serial clock limits, in kHz
`define SRAS_SPI_MAX_KHZ     10000
`define SRAS_TWI_MAX_KHZ     1000

`endif

// ### verilog/sras_sync2.v
// two-stage reset release synchroniser
`timescale 1ns/1ps
module sras_sync2 (
    input  wire clk_i,
    input  wire arst_n_i,
    output reg  rst_n_o
);
    reg stage1;

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stage1  <= 1'b0;
            rst_n_o <= 1'b0;
        end else begin
            stage1  <= 1'b1;
            rst_n_o <= stage1;
        end
    end
endmodule

// ### verilog/sras_top.v
// spi register access with shadow registers and rms window selection
`timescale 1ns/1ps
`include "sras_map.vh"

// Notes on behaviour
// - bypass clear: window from voltage zero crossings
// - bypass set: stored count is the window
// - fixed counts below four become four
// - spi only, serial clock up to 10 mhz
// - data output driven even with select high
// - direction bit high reads, low writes
// - response word carries previous command result
// - writes store 32 bits, reads ignore them
// - customer eeprom writes need the access code
// - free-space eeprom writes always accepted
// - reads allowed always, code irrelevant
// - power-up copies eeprom into shadows
// - shadow writes act at once
// - shadow writes lost on reset
// - eeprom reads return 26 data bits with ecc
// - ecc status 00 ok, 01 fixed, 10 failed
module sras_top (
    input  wire        clk_i,
    input  wire        arst_n_i,
    input  wire        sclk_i,
    input  wire        cs_n_i,
    input  wire        mosi_i,
    input  wire        vzc_i,
    input  wire [31:0] nv_word0_i,
    input  wire [31:0] nv_word1_i,
    input  wire [31:0] nv_word2_i,
    input  wire [31:0] nv_word3_i,
    input  wire [31:0] nv_word4_i,
    input  wire [1:0]  nv_ecc_i,
    output reg         miso_o,
    output reg         miso_oe_n_o,
    output reg         nv_wr_o,
    output reg  [2:0]  nv_wr_idx_o,
    output reg  [31:0] nv_wr_data_o,
    output reg         free_wr_o,
    output reg  [6:0]  free_wr_addr_o,
    output reg  [31:0] free_wr_data_o,
    output reg         access_open_o,
    output reg         win_dynamic_o,
    output reg  [9:0]  win_len_o,
    output reg         win_end_o
);
    // ****************************************************************
    // reset release
    // ****************************************************************
    wire rst_n;

    sras_sync2 u_sync (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .rst_n_o  (rst_n)
    );

    // ****************************************************************
    // shadow copy and power-up load
    // ****************************************************************
    reg  [31:0] shadow [0:4];
    reg         loaded;
    reg  [31:0] nv_sel;
    reg  [9:0]  next_len;
    wire [31:0] cfg = shadow[4];
    integer     k;

    // inputs are sampled on clk, so sclk edges are found by comparison
    reg  sclk_d;
    reg  vzc_d;
    // limitation: clk must run about eight times sclk or faster
    wire sclk_rise = sclk_i & ~sclk_d;
    wire sclk_fall = ~sclk_i & sclk_d;

    reg  [5:0]  bit_cnt;
    reg  [39:0] rx_sr;
    reg  [31:0] tx_sr;
    reg  [31:0] resp;
    reg  [9:0]  win_cnt;

    wire [39:0] rx_next = {rx_sr[38:0], mosi_i};
    wire [6:0]  f_addr  = rx_next[39:33];
    wire        f_read  = rx_next[32] == `SRAS_DIR_READ;
    wire [31:0] f_data  = rx_next[31:0];
    wire        f_done  = sclk_rise & ~cs_n_i & (bit_cnt == `SRAS_FRAME_BITS - 6'd1);
    wire        in_ee   = f_addr >= `SRAS_EE_FIRST && f_addr <= `SRAS_EE_LAST;
    wire        in_sh   = f_addr >= `SRAS_SH_FIRST && f_addr <= `SRAS_SH_LAST;
    wire        in_free = f_addr <= `SRAS_FREE_LAST;
    wire [2:0]  ee_idx  = f_addr[2:0] - 3'd3;

    always @* begin
        case (ee_idx)
            3'd0:    nv_sel = nv_word0_i;
            3'd1:    nv_sel = nv_word1_i;
            3'd2:    nv_sel = nv_word2_i;
            3'd3:    nv_sel = nv_word3_i;
            default: nv_sel = nv_word4_i;
        endcase
    end

    always @* begin
        next_len = cfg[`SRAS_N_MSB:`SRAS_N_LSB];
        if (next_len < `SRAS_N_MIN) begin
            next_len = `SRAS_N_MIN;
        end
    end

    // ****************************************************************
    // serial frame engine
    // ****************************************************************
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            for (k = 0; k < 5; k = k + 1) begin
                shadow[k] <= 32'h0000_0000;
            end
            loaded         <= 1'b0;
            sclk_d         <= 1'b0;
            vzc_d          <= 1'b0;
            bit_cnt        <= 6'h00;
            rx_sr          <= 40'h00_0000_0000;
            tx_sr          <= 32'h0000_0000;
            resp           <= 32'h0000_0000;
            miso_o         <= 1'b0;
            miso_oe_n_o    <= 1'b0;
            nv_wr_o        <= 1'b0;
            nv_wr_idx_o    <= 3'h0;
            nv_wr_data_o   <= 32'h0000_0000;
            free_wr_o      <= 1'b0;
            free_wr_addr_o <= 7'h00;
            free_wr_data_o <= 32'h0000_0000;
            access_open_o  <= 1'b0;
        end else begin
            sclk_d      <= sclk_i;
            vzc_d       <= vzc_i;
            nv_wr_o     <= 1'b0;
            free_wr_o   <= 1'b0;
            miso_oe_n_o <= 1'b0;
            if (!loaded) begin
                shadow[0] <= nv_word0_i;
                shadow[1] <= nv_word1_i;
                shadow[2] <= nv_word2_i;
                shadow[3] <= nv_word3_i;
                shadow[4] <= nv_word4_i;
                loaded    <= 1'b1;
            end
            if (cs_n_i) begin
                // frame aborted or idle: realign; miso keeps its last level
                bit_cnt <= 6'h00;
            end else if (sclk_rise) begin
                rx_sr   <= rx_next;
                bit_cnt <= f_done ? 6'h00 : bit_cnt + 6'd1;
                if (bit_cnt == 6'd7) begin
                    tx_sr <= resp;
                end
            end else if (sclk_fall && bit_cnt >= 6'd8) begin
                miso_o <= tx_sr[31];
                tx_sr  <= {tx_sr[30:0], 1'b0};
            end
            if (f_done) begin
                if (f_read) begin
                    if (in_ee) begin
                        resp <= {4'h0, nv_ecc_i, nv_sel[`SRAS_EE_DATA_MSB:0]};
                    end else if (in_sh) begin
                        resp <= shadow[ee_idx];
                    end else if (f_addr == `SRAS_ACCESS_ADDR) begin
                        resp <= {31'h0000_0000, access_open_o};
                    end else begin
                        resp <= 32'h0000_0000;
                    end
                end else begin
                    resp <= 32'h0000_0000;
                    if (f_addr == `SRAS_ACCESS_ADDR) begin
                        access_open_o <= f_data == `SRAS_ACCESS_KEY;
                    end else if (in_sh) begin
                        shadow[ee_idx] <= f_data;
                    end else if (in_ee && access_open_o) begin
                        nv_wr_o      <= 1'b1;
                        nv_wr_idx_o  <= ee_idx;
                        nv_wr_data_o <= f_data;
                    end else if (in_free) begin
                        free_wr_o      <= 1'b1;
                        free_wr_addr_o <= f_addr;
                        free_wr_data_o <= f_data;
                    end
                end
            end
        end
    end

    // ****************************************************************
    // rms window framing
    // ****************************************************************
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            win_dynamic_o <= 1'b1;
            win_len_o     <= `SRAS_N_MIN;
            win_end_o     <= 1'b0;
            win_cnt       <= 10'h000;
        end else begin
            win_dynamic_o <= ~cfg[`SRAS_BYPASS_BIT];
            win_len_o     <= next_len;
            win_end_o     <= 1'b0;
            if (!cfg[`SRAS_BYPASS_BIT]) begin
                // one window per rising voltage zero crossing
                win_cnt   <= 10'h000;
                win_end_o <= vzc_i & ~vzc_d;
            end else if (win_cnt + 10'd1 >= next_len) begin
                win_cnt   <= 10'h000;
                win_end_o <= 1'b1;
            end else begin
                win_cnt <= win_cnt + 10'd1;
            end
        end
    end
endmodule

// ### testbench/sras_chk.sv
// port assertions for the serial access block
`timescale 1ns/1ps
module sras_chk (
    input wire       clk_i,
    input wire       arst_n_i,
    input wire       cs_n_i,
    input wire       vzc_i,
    input wire       miso_o,
    input wire       miso_oe_n_o,
    input wire       nv_wr_o,
    input wire [2:0] nv_wr_idx_o,
    input wire       free_wr_o,
    input wire [6:0] free_wr_addr_o,
    input wire       access_open_o,
    input wire       win_dynamic_o,
    input wire [9:0] win_len_o,
    input wire       win_end_o
);
    // ****************
    // port relations
    // ****************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    property p_oe; miso_oe_n_o == 1'b0; endproperty
    a_oe: assert property (p_oe) else $error("miso released");
    property p_hold; cs_n_i && $past(cs_n_i) |-> $stable(miso_o); endproperty
    a_hold: assert property (p_hold) else $error("miso moved while idle");
    property p_nvpulse; nv_wr_o |=> !nv_wr_o; endproperty
    a_nvpulse: assert property (p_nvpulse) else $error("long write pulse");
    property p_nvopen; nv_wr_o |-> access_open_o && nv_wr_idx_o <= 3'h4; endproperty
    a_nvopen: assert property (p_nvopen) else $error("locked write passed");
    property p_free; free_wr_o |-> free_wr_addr_o <= 7'h0A && !$past(cs_n_i); endproperty
    a_free: assert property (p_free) else $error("bad free write");
    property p_min; win_len_o >= 10'h004; endproperty
    a_min: assert property (p_min) else $error("window below four");
    property p_fix; win_end_o && !win_dynamic_o |=> !win_end_o [*3]; endproperty
    a_fix: assert property (p_fix) else $error("fixed window too short");
    property p_dyn; win_dynamic_o && $rose(vzc_i) |-> ##[0:4] win_end_o; endproperty
    a_dyn: assert property (p_dyn) else $error("crossing did not end window");
    c_nv: cover property (nv_wr_o);
    c_free: cover property (free_wr_o);
    c_fix: cover property (win_end_o && !win_dynamic_o);
endmodule

// ### testbench/sras_spi_master.sv
// spi master model driving 40-bit frames
`timescale 1ns/1ps
module sras_spi_master (
    input  wire clk_i,
    input  wire miso_i,
    output reg  sclk_o,
    output reg  cs_n_o,
    output reg  mosi_o
);
    // ****************
    // frame engine
    // ****************
    // sole target on this bus, miso is never shared
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // five clocks per half bit keeps sclk at 10 mhz
    task half;
        begin
            repeat (5) @(posedge clk_i);
            #1;
        end
    endtask
    task xfer(input [6:0] a, input rw, input [31:0] d, output [31:0] r);
        reg     [39:0] f;
        integer        i;
        begin
            f = {a, rw, d};
            cs_n_o = 1'b0;
            for (i = 0; i < 40; i = i + 1) begin
                sclk_o = 1'b0;
                mosi_o = f[39 - i];
                half;
                if (i > 7) r[39 - i] = miso_i;
                sclk_o = 1'b1;
                half;
            end
            sclk_o = 1'b0;
            half;
            cs_n_o = 1'b1;
            // idle mosi shows no stale bit
            mosi_o = ~mosi_o;
            half;
        end
    endtask
    // frame cut short by raising select after n bits
    task cut(input integer n);
        integer i;
        begin
            cs_n_o = 1'b0;
            for (i = 0; i < n; i = i + 1) begin
                sclk_o = 1'b0;
                mosi_o = 1'b1;
                half;
                sclk_o = 1'b1;
                half;
            end
            sclk_o = 1'b0;
            half;
            cs_n_o = 1'b1;
            half;
        end
    endtask
endmodule

// ### testbench/tb_sras_top.sv
// self-checking testbench for the serial access block
`timescale 1ns/1ps
module tb_sras_top;
    // ****************
    // harness
    // ****************
    reg         clk_i = 1'b0, arst_n_i = 1'b0, vzc_i = 1'b0;
    reg  [1:0]  nv_ecc_i = 2'h0;
    reg  [31:0] nv_word4_i = 32'h0000_0000, p, r;
    wire [31:0] nv_word0_i = 32'h1234_5678, nv_word1_i = 32'h0, nv_word2_i = 32'h0;
    wire [31:0] nv_word3_i = 32'h0, nv_wr_data_o, free_wr_data_o;
    wire        sclk_i, cs_n_i, mosi_i, miso_o, miso_oe_n_o, nv_wr_o, free_wr_o;
    wire        access_open_o, win_dynamic_o, win_end_o;
    wire [2:0]  nv_wr_idx_o;
    wire [6:0]  free_wr_addr_o;
    wire [9:0]  win_len_o;
    integer     n_mismatch = 0, comparisons = 0, n_nv = 0, n_free = 0, n_end = 0, k;
    sras_top i_dut (
        .clk_i          (clk_i),
        .arst_n_i       (arst_n_i),
        .sclk_i         (sclk_i),
        .cs_n_i         (cs_n_i),
        .mosi_i         (mosi_i),
        .vzc_i          (vzc_i),
        .nv_word0_i     (nv_word0_i),
        .nv_word1_i     (nv_word1_i),
        .nv_word2_i     (nv_word2_i),
        .nv_word3_i     (nv_word3_i),
        .nv_word4_i     (nv_word4_i),
        .nv_ecc_i       (nv_ecc_i),
        .miso_o         (miso_o),
        .miso_oe_n_o    (miso_oe_n_o),
        .nv_wr_o        (nv_wr_o),
        .nv_wr_idx_o    (nv_wr_idx_o),
        .nv_wr_data_o   (nv_wr_data_o),
        .free_wr_o      (free_wr_o),
        .free_wr_addr_o (free_wr_addr_o),
        .free_wr_data_o (free_wr_data_o),
        .access_open_o  (access_open_o),
        .win_dynamic_o  (win_dynamic_o),
        .win_len_o      (win_len_o),
        .win_end_o      (win_end_o)
    );
    sras_spi_master i_master (.clk_i(clk_i), .miso_i(miso_o), .sclk_o(sclk_i),
        .cs_n_o(cs_n_i), .mosi_o(mosi_i));
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        n_nv <= n_nv + (nv_wr_o === 1'b1);
        n_free <= n_free + (free_wr_o === 1'b1);
        n_end <= n_end + (win_end_o === 1'b1);
    end
    task step(input integer n);
        begin
            repeat (n) @(posedge clk_i);
            #1;
        end
    endtask
    task cmp(input [39:0] got, input [39:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    // read data word is junk on purpose, the device must ignore it
    task rd(input [6:0] a);
        begin
            i_master.xfer(a, 1'b1, 32'hFFFF_FFFF, p);
            i_master.xfer(7'h7F, 1'b1, 32'h0, r);
        end
    endtask
    task wr(input [6:0] a, input [31:0] d);
        i_master.xfer(a, 1'b0, d, p);
    endtask
    task print_verdict;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
            if (n_mismatch == 0 && comparisons > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial begin
        #500000;
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: watchdog expired", $time);
        print_verdict;
    end
    initial begin
        step(3);
        arst_n_i = 1'b1;
        step(6);
        cmp(win_dynamic_o, 1);
        cmp(miso_oe_n_o, 0);
        for (k = 0; k < 3; k = k + 1) begin
            vzc_i = 1'b1;
            step(10);
            vzc_i = 1'b0;
            step(10);
        end
        cmp(n_end, 3);
        $display("test window dynamic done");
        rd(7'h1B);
        cmp(r, nv_word0_i);
        for (k = 0; k < 3; k = k + 1) begin
            nv_ecc_i = k[1:0];
            rd(7'h0B);
            cmp(r, {4'h0, nv_ecc_i, nv_word0_i[25:0]});
        end
        $display("test reads done");
        wr(7'h0C, 32'hA5A5_0001);
        wr(7'h05, 32'h0000_BEEF);
        cmp(n_nv, 0);
        cmp(n_free, 1);
        cmp({free_wr_addr_o, free_wr_data_o}, {7'h05, 32'h0000_BEEF});
        // a cut frame must leave the next one aligned
        i_master.cut(20);
        wr(7'h05, 32'h0000_CAFE);
        cmp(n_free, 2);
        cmp({free_wr_addr_o, free_wr_data_o}, {7'h05, 32'h0000_CAFE});
        wr(7'h2F, 32'h5A5A_C0DE);
        rd(7'h2F);
        cmp(p, 0);
        cmp(r, 1);
        wr(7'h0C, 32'hA5A5_0002);
        cmp(n_nv, 1);
        cmp({nv_wr_idx_o, nv_wr_data_o}, {3'h1, 32'hA5A5_0002});
        $display("test writes done");
        // vzc stays low from here on, as in current-only use
        wr(7'h1F, 32'h0100_8000);
        cmp({win_dynamic_o, win_len_o}, {1'b0, 10'h004});
        wr(7'h1F, 32'h0102_4000);
        rd(7'h1F);
        cmp(r, 32'h0102_4000);
        k = n_end;
        step(36);
        cmp(n_end - k, 4);
        cmp(win_len_o, 9);
        $display("test window fixed done");
        nv_word4_i = 32'h0100_C000;
        arst_n_i = 1'b0;
        step(3);
        arst_n_i = 1'b1;
        step(6);
        cmp({access_open_o, win_dynamic_o, win_len_o}, {2'b00, 10'h004});
        rd(7'h1F);
        cmp(r, nv_word4_i);
        $display("test reset done");
        print_verdict;
    end
endmodule
bind sras_top sras_chk i_chk (
    .clk_i          (clk_i),
    .arst_n_i       (arst_n_i),
    .cs_n_i         (cs_n_i),
    .vzc_i          (vzc_i),
    .miso_o         (miso_o),
    .miso_oe_n_o    (miso_oe_n_o),
    .nv_wr_o        (nv_wr_o),
    .nv_wr_idx_o    (nv_wr_idx_o),
    .free_wr_o      (free_wr_o),
    .free_wr_addr_o (free_wr_addr_o),
    .access_open_o  (access_open_o),
    .win_dynamic_o  (win_dynamic_o),
    .win_len_o      (win_len_o),
    .win_end_o      (win_end_o)
);
